// [rtl/slave_reg_monitor_defs.vh]
// constants for the slave registration status monitor
`ifndef SLAVE_REG_MONITOR_DEFS_VH
`define SLAVE_REG_MONITOR_DEFS_VH

// apb byte addresses
`define ADDR_CTRL        12'h000
`define ADDR_CMD         12'h004
`define ADDR_STATE       12'h008
`define ADDR_PART        12'h00C
`define ADDR_COMMERR     12'h010
`define ADDR_DUPERR      12'h014
`define ADDR_MISSING     12'h018
`define ADDR_UNREG       12'h01C
`define ADDR_EVONLY      12'h020
`define ADDR_DSTAT_VALID 12'h024
`define ADDR_TABLE_BASE  12'h100
`define ADDR_EXAMPLE_BASE 12'h200

// control register fields
`define CTRL_CHECK_EN    0
`define CTRL_WAIT_ALL    1
`define CTRL_MANUAL      2
`define CTRL_RATE_SLOW   3
`define CTRL_TIME_LSB    8
`define CTRL_RESET       32'h0000_0000

// command register bits (write one to act)
`define CMD_STATUS_REQ   0
`define CMD_START_IO     1
`define CMD_BUILD_EX     2

// network state word fields
`define STATE_CMP_ERR    1
`define STATE_ALL_PART   6

// table entry: valid in bit 8, model in 7:0
`define ENTRY_VALID      8

// participation time, seconds
`define PART_TIME_SLOW_S 30
`define PART_TIME_FAST_S 10
`define CLK_HZ           10000000

`endif

// [rtl/part_timer.v]
// participation timer: one-shot down counter
`timescale 1ns/10ps
`default_nettype none
module part_timer #(
    parameter WIDTH = 32
) (
    // clock and reset
    input  wire             clk,
    input  wire             reset,
    // control
    input  wire             start,
    input  wire             hold,
    input  wire [WIDTH-1:0] load_val,
    // status
    output reg              expired_r
);
    reg [WIDTH-1:0] cnt_r;
    reg             run_r;

    always @(posedge clk) begin
        if (reset) begin
            cnt_r     <= {WIDTH{1'b0}};
            run_r     <= 1'b0;
            expired_r <= 1'b0;
        end else if (start) begin
            cnt_r     <= load_val;
            run_r     <= 1'b1;
            expired_r <= 1'b0;
        end else if (run_r && !hold) begin
            if (cnt_r <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                run_r     <= 1'b0;
                expired_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/led_flasher.v]
// network status indicator driver with red flash
`timescale 1ns/10ps
`default_nettype none
module led_flasher #(
    parameter HALF = 2500000
) (
    // clock and reset
    input  wire clk,
    input  wire reset,
    // request
    input  wire flash_req,
    input  wire ok,
    // indicator
    output reg  green_r,
    output reg  red_r
);
    reg [31:0] cnt_r;
    reg        phase_r;

    always @(posedge clk) begin
        if (reset) begin
            cnt_r   <= 32'h0000_0000;
            phase_r <= 1'b0;
            green_r <= 1'b0;
            red_r   <= 1'b0;
        end else begin
            if (cnt_r >= HALF - 1) begin
                cnt_r   <= 32'h0000_0000;
                phase_r <= ~phase_r;
            end else begin
                cnt_r <= cnt_r + 32'h0000_0001;
            end
            red_r   <= flash_req & phase_r;
            green_r <= ok & ~flash_req;
        end
    end
endmodule
`default_nettype wire

// [rtl/slave_reg_monitor.v]
// slave registration and participation status monitor, apb slave
//
// Functional notes
// - a joining slave sets the participation bit at its node address
// - participation bits stay set after the slave drops off
// - error bit set while a participating slave is silent, cleared after
// - detailed status is delivered only after a status-read command
// - duplication bit set on duplicate address or unstable stop
// - per-node bit for registered slaves not yet joined
// - per-node bit for unregistered slaves trying to join
// - check enabled: unlisted or mismatched slaves are refused
// - any mismatch sets comparison error, state word bit 1
// - after a mismatch, cyclic exchange starts unless wait-all mode
// - all registered joined within participation time sets bit 6
// - all registered joined and no stranger keeps comparison error clear
// - unregistered join sets comparison error and flashes red
// - missing at expiry sets error and red; cleared when it joins
// - wait-all mode ignores the participation time limit
// - participation time 30 s at slow rate, otherwise 10 s; a nonzero ctrl time field (bits 31:8) sets it in seconds instead
// - manual startup starts the timer at exchange start
// - event-only slaves flagged as unable to join cyclic exchange
// - on request, build an example table from joined slaves
// - with the check enabled, wait-all mode holds exchange until all registered joined
// - basic status group refreshes continuously
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "slave_reg_monitor_defs.vh"
module slave_reg_monitor #(
    parameter NODES       = 64,
    parameter AW          = 6,
    parameter CLK_HZ      = `CLK_HZ,
    parameter FLASH_HALF  = 2500000
) (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // network events from the link layer
    input  wire        join_evt,
    input  wire [AW-1:0] join_node,
    input  wire [7:0]  join_model,
    input  wire        join_event_only,
    input  wire        lost_evt,
    input  wire        restore_evt,
    input  wire        dup_evt,
    input  wire        unstable_evt,
    input  wire [AW-1:0] evt_node,
    // cyclic exchange and indicator
    output reg         io_run_r,
    output reg         join_ack_r,
    output reg         join_refuse_r,
    output wire        ns_green,
    output wire        ns_red
);
    localparam [31:0] SLOW_T = `PART_TIME_SLOW_S * CLK_HZ;
    localparam [31:0] FAST_T = `PART_TIME_FAST_S * CLK_HZ;

    // control and per-node state
    reg [31:0]      ctrl_r;
    reg [NODES-1:0] part_r;
    reg [NODES-1:0] err_r;
    reg [NODES-1:0] dup_r;
    reg [NODES-1:0] unreg_r;
    reg [NODES-1:0] evo_r;
    reg [8:0]       table_r [0:NODES-1];
    reg [8:0]       example_r [0:NODES-1];
    wire [NODES-1:0] reg_mask;
    reg [NODES-1:0] dstat_dup_r;
    reg [NODES-1:0] dstat_miss_r;
    reg [NODES-1:0] dstat_unreg_r;
    reg [NODES-1:0] dstat_evo_r;
    reg             dstat_valid_r;
    reg             cmp_err_r;
    reg             all_part_r;
    reg             started_r;
    reg             opened_r;
    reg             start_pulse_r;
    reg             man_start_r;
    reg [31:0]      time_cfg;
    wire            expired;
    wire [NODES-1:0] missing;
    wire            wait_all   = ctrl_r[`CTRL_WAIT_ALL];
    wire            check_en   = ctrl_r[`CTRL_CHECK_EN];
    wire            manual     = ctrl_r[`CTRL_MANUAL];
    integer         i;

    // apb phases
    wire acc = psel & penable & pready;
    wire wr  = acc & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;

    // register write strobes, taken at the access edge
    wire wr_ctrl  = wr && paddr == `ADDR_CTRL;
    wire wr_cmd   = wr && paddr == `ADDR_CMD;
    wire wr_table = wr && paddr[11:8] == 4'h1 && paddr[1:0] == 2'b00;
    wire cmd_stat = wr_cmd && pwdata[`CMD_STATUS_REQ];
    wire cmd_go   = wr_cmd && pwdata[`CMD_START_IO];
    wire cmd_ex   = wr_cmd && pwdata[`CMD_BUILD_EX];

    function table_match;
        input [8:0] ent;
        input [7:0] model;
        begin
            table_match = ent[`ENTRY_VALID] && (ent[7:0] == model);
        end
    endfunction

    // registration check result for the slave now trying to join
    wire join_ok = !check_en || table_match(table_r[join_node], join_model);

    // one valid bit per table entry
    genvar gi;
    generate
        for (gi = 0; gi < NODES; gi = gi + 1) begin : g_mask
            assign reg_mask[gi] = table_r[gi][`ENTRY_VALID];
        end
    endgenerate

    // registered but not yet joined
    assign missing = reg_mask & ~part_r;

    // participation time: configured or rate default
    always @* begin
        if (ctrl_r[31:`CTRL_TIME_LSB] != 24'h00_0000)
            time_cfg = ctrl_r[31:`CTRL_TIME_LSB] * CLK_HZ;
        else if (ctrl_r[`CTRL_RATE_SLOW])
            time_cfg = SLOW_T;
        else
            time_cfg = FAST_T;
    end

    // wait-all holds the count, so the time limit never runs out
    part_timer #(
        .WIDTH (32)
    ) u_timer (
        .clk       (clk),
        .reset     (reset),
        .start     (start_pulse_r),
        .hold      (wait_all),
        .load_val  (time_cfg),
        .expired_r (expired)
    );

    // red flashes while the comparison error stands
    led_flasher #(
        .HALF (FLASH_HALF)
    ) u_led (
        .clk       (clk),
        .reset     (reset),
        .flash_req (cmp_err_r),
        .ok        (io_run_r),
        .green_r   (ns_green),
        .red_r     (ns_red)
    );

    // startup: power-on or manual start command
    always @(posedge clk) begin
        if (reset) begin
            started_r     <= 1'b0;
            start_pulse_r <= 1'b0;
        end else begin
            start_pulse_r <= 1'b0;
            // wait for the first control write so the host's settings apply
            if (opened_r && !started_r && (!manual || man_start_r)) begin
                started_r     <= 1'b1;
                start_pulse_r <= 1'b1;
            end
        end
    end

    // per-node flags and join decision
    always @(posedge clk) begin
        if (reset) begin
            part_r        <= {NODES{1'b0}};
            err_r         <= {NODES{1'b0}};
            dup_r         <= {NODES{1'b0}};
            unreg_r       <= {NODES{1'b0}};
            evo_r         <= {NODES{1'b0}};
            join_ack_r    <= 1'b0;
            join_refuse_r <= 1'b0;
        end else begin
            join_ack_r    <= 1'b0;
            join_refuse_r <= 1'b0;
            // a loss in the same cycle as a restore wins
            if (restore_evt)
                err_r[evt_node] <= 1'b0;
            if (lost_evt && part_r[evt_node])
                err_r[evt_node] <= 1'b1;
            if (dup_evt || unstable_evt)
                dup_r[evt_node] <= 1'b1;
            if (join_evt) begin
                if (join_event_only) begin
                    evo_r[join_node] <= 1'b1;
                    join_refuse_r    <= 1'b1;
                end else if (check_en &&
                        !table_match(table_r[join_node], join_model)) begin
                    unreg_r[join_node] <= 1'b1;
                    join_refuse_r      <= 1'b1;
                end else begin
                    part_r[join_node] <= 1'b1;
                    unreg_r[join_node] <= 1'b0;
                    join_ack_r        <= 1'b1;
                end
            end
        end
    end

    // network state word and exchange control
    always @(posedge clk) begin
        if (reset) begin
            cmp_err_r  <= 1'b0;
            all_part_r <= 1'b0;
            io_run_r   <= 1'b0;
        end else begin
            if (check_en && missing == {NODES{1'b0}} &&
                    (wait_all || !expired) && started_r)
                all_part_r <= 1'b1;
            // comparison error tracks the present state, so it clears
            // as soon as the missing slave joins
            if (!check_en)
                cmp_err_r <= 1'b0;
            else if (unreg_r != {NODES{1'b0}})
                cmp_err_r <= 1'b1;
            else if (expired && !wait_all && missing != {NODES{1'b0}})
                cmp_err_r <= 1'b1;
            else
                cmp_err_r <= 1'b0;
            // with the check off the exchange starts at once
            if (started_r) begin
                if (wait_all && check_en)
                    io_run_r <= all_part_r;
                else if (!check_en || expired || all_part_r || cmp_err_r)
                    io_run_r <= 1'b1;
            end
        end
    end

    // apb register side and commands
    always @(posedge clk) begin
        if (reset) begin
            ctrl_r        <= `CTRL_RESET;
            opened_r      <= 1'b0;
            man_start_r   <= 1'b0;
            dstat_valid_r <= 1'b0;
            dstat_dup_r   <= {NODES{1'b0}};
            dstat_miss_r  <= {NODES{1'b0}};
            dstat_unreg_r <= {NODES{1'b0}};
            dstat_evo_r   <= {NODES{1'b0}};
            for (i = 0; i < NODES; i = i + 1) begin
                table_r[i]   <= 9'h000;
                example_r[i] <= 9'h000;
            end
        end else begin
            if (wr_ctrl) begin
                ctrl_r   <= pwdata;
                opened_r <= 1'b1;
            end
            if (cmd_go)
                man_start_r <= 1'b1;
            // detailed status is a snapshot taken only on request
            if (cmd_stat) begin
                dstat_dup_r   <= dup_r;
                dstat_miss_r  <= missing;
                dstat_unreg_r <= unreg_r;
                dstat_evo_r   <= evo_r;
                dstat_valid_r <= 1'b1;
            end
            if (wr_table && paddr[7:2] < NODES)
                table_r[paddr[AW+1:2]] <= pwdata[8:0];
            for (i = 0; i < NODES; i = i + 1)
                if (cmd_ex)
                    example_r[i] <= part_r[i] ?
                                    {1'b1, example_r[i][7:0]} : 9'h000;
            // only accepted joins leave their model in the example table
            if (join_evt && !join_event_only && join_ok)
                example_r[join_node][7:0] <= join_model;
        end
    end

    // read mux
    function [31:0] rd_word;
        input [11:0] a;
        begin
            case (a)
            `ADDR_CTRL:        rd_word = ctrl_r;
            `ADDR_STATE:       rd_word = {25'h0, all_part_r, 4'h0,
                                          cmp_err_r, 1'b0};
            `ADDR_PART:        rd_word = part_r[31:0];
            `ADDR_COMMERR:     rd_word = err_r[31:0];
            `ADDR_DUPERR:      rd_word = dstat_dup_r[31:0];
            `ADDR_MISSING:     rd_word = dstat_miss_r[31:0];
            `ADDR_UNREG:       rd_word = dstat_unreg_r[31:0];
            `ADDR_EVONLY:      rd_word = dstat_evo_r[31:0];
            `ADDR_DSTAT_VALID: rd_word = {31'h0, dstat_valid_r};
            default: begin
                if (a[11:8] == 4'h1 && a[7:2] < NODES)
                    rd_word = {23'h0, table_r[a[AW+1:2]]};
                else if (a[11:8] == 4'h2 && a[7:2] < NODES)
                    rd_word = {23'h0, example_r[a[AW+1:2]]};
                else
                    rd_word = 32'h0000_0000;
            end
            endcase
        end
    endfunction

    function mapped;
        input [11:0] a;
        begin
            mapped = (a <= `ADDR_DSTAT_VALID && a[1:0] == 2'b00) ||
                     ((a[11:8] == 4'h1 || a[11:8] == 4'h2) &&
                      a[7:2] < NODES && a[1:0] == 2'b00);
        end
    endfunction

    // no wait state: setup, then access with pready
    // read data is latched at the setup edge and stands in the access
    always @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped(paddr);
            if (rd_setup)
                prdata <= rd_word(paddr);
        end
    end
endmodule
`default_nettype wire

// [dv/slave_reg_monitor_properties.sv]
// assertion checker for the slave registration monitor
`timescale 1ns/10ps
`default_nettype none
module slave_reg_monitor_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // events and outputs
    input wire logic        join_evt,
    input wire logic        join_ack_r,
    input wire logic        join_refuse_r,
    input wire logic        io_run_r,
    input wire logic        ns_green,
    input wire logic        ns_red
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_ready_access;
        psel && !penable |=> pready;
    endproperty
    a_ready_access: assert property (p_ready_access)
        else $error("access cycle without ready");
    property p_ready_cause;
        pready |-> psel && penable && $past(psel && !penable);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready outside an access cycle");
    property p_unmapped;
        psel && penable && paddr == 12'h800 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    property p_join_answer;
        join_evt |=> join_ack_r != join_refuse_r;
    endproperty
    a_join_answer: assert property (p_join_answer)
        else $error("join attempt not answered once");
    property p_answer_cause;
        join_ack_r || join_refuse_r |-> $past(join_evt);
    endproperty
    a_answer_cause: assert property (p_answer_cause)
        else $error("join answer without attempt");
    property p_io_stays;
        io_run_r |=> io_run_r;
    endproperty
    a_io_stays: assert property (p_io_stays)
        else $error("cyclic exchange stopped");
    property p_ns_excl;
        !(ns_red && ns_green);
    endproperty
    a_ns_excl: assert property (p_ns_excl)
        else $error("indicator red and green together");
endmodule
bind slave_reg_monitor slave_reg_monitor_props slave_reg_monitor_props_i (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .join_evt(join_evt), .join_ack_r(join_ack_r),
    .join_refuse_r(join_refuse_r), .io_run_r(io_run_r),
    .ns_green(ns_green), .ns_red(ns_red));
`default_nettype wire

// [dv/slave_net_model.sv]
// model of the slave units on the field network
`timescale 1ns/10ps
`default_nettype none
module slave_net_model (
    // clock
    input wire logic        clk,
    // join attempts
    output logic            join_evt = 1'b0,
    output logic [5:0]      join_node = 6'h00,
    output logic [7:0]      join_model = 8'h00,
    output logic            join_event_only = 1'b0,
    // link events
    output logic            lost_evt = 1'b0,
    output logic            restore_evt = 1'b0,
    output logic            dup_evt = 1'b0,
    output logic            unstable_evt = 1'b0,
    output logic [5:0]      evt_node = 6'h00
);
    // one join attempt: node, model and event-only flag driven for one cycle, then inverted
    task attempt(input logic [5:0] n, input logic [7:0] m, input logic eo);
        @(posedge clk);
        join_evt <= 1'b1;
        join_node <= n;
        join_model <= m;
        join_event_only <= eo;
        @(posedge clk);
        join_evt <= 1'b0;
        join_node <= ~n;
        join_model <= ~m;
        join_event_only <= ~eo;
    endtask
    // k is one-hot: lost, restore, duplicate, unstable
    task evt(input logic [3:0] k, input logic [5:0] n);
        @(posedge clk);
        {lost_evt, restore_evt, dup_evt, unstable_evt} <= k;
        evt_node <= n;
        @(posedge clk);
        {lost_evt, restore_evt, dup_evt, unstable_evt} <= 4'h0;
        evt_node <= ~n;
    endtask
endmodule
`default_nettype wire

// [dv/slave_reg_monitor_tb.sv]
// self-checking bench for the slave registration monitor
`timescale 1ns/10ps
`default_nettype none
`include "slave_reg_monitor_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH at %0t got %h exp %h", $time, g, e); end end
module slave_reg_monitor_tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, io_run_r, join_ack_r, join_refuse_r;
    wire         ns_green, ns_red, join_evt, join_event_only;
    wire         lost_evt, restore_evt, dup_evt, unstable_evt;
    wire  [5:0]  join_node, evt_node;
    wire  [7:0]  join_model;
    int          num_errors = 0;
    int          n_tests = 0;
    logic [4:0]  cnt;
    logic [32:0] rdq[$];
    logic [1:0]  ackq[$];
    logic [32:0] re;
    logic [1:0]  ae;
    logic [7:0]  m0, m1;

    always #50 clk = ~clk;

    slave_reg_monitor #(.CLK_HZ(10), .FLASH_HALF(4)) slave_reg_monitor_i (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .join_evt(join_evt),
        .join_node(join_node), .join_model(join_model),
        .join_event_only(join_event_only), .lost_evt(lost_evt),
        .restore_evt(restore_evt), .dup_evt(dup_evt),
        .unstable_evt(unstable_evt), .evt_node(evt_node),
        .io_run_r(io_run_r), .join_ack_r(join_ack_r),
        .join_refuse_r(join_refuse_r), .ns_green(ns_green), .ns_red(ns_red));
    slave_net_model net_i (
        .clk(clk), .join_evt(join_evt), .join_node(join_node),
        .join_model(join_model), .join_event_only(join_event_only),
        .lost_evt(lost_evt), .restore_evt(restore_evt), .dup_evt(dup_evt),
        .unstable_evt(unstable_evt), .evt_node(evt_node));

    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!pready && k < 20);
        if (k >= 20) begin
            num_errors++;
            wrap_up;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] d);
        rdq.push_back({1'b0, d});
        xfer(1'b0, a, 32'h0);
    endtask
    task join_exp(input logic [5:0] n, input logic [7:0] m,
                  input logic eo, input logic ok);
        ackq.push_back(ok ? 2'b10 : 2'b01);
        net_i.attempt(n, m, eo);
    endtask
    // reset, then registration table for nodes 0 and 1
    task start(input logic [31:0] ctrl);
        reset <= 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        wr(`ADDR_TABLE_BASE, {23'h0, 1'b1, m0});
        wr(`ADDR_TABLE_BASE + 12'h004, {23'h0, 1'b1, m1});
        wr(`ADDR_CTRL, ctrl);
    endtask
    // settle for a few cycles, then count red over two flash periods
    task red_count;
        repeat (4) @(posedge clk);
        cnt = 5'h00;
        repeat (16) begin
            @(posedge clk);
            cnt += {4'h0, ns_red};
        end
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && rdq.size() > 0) begin
            re = rdq.pop_front();
            `CHK({pslverr, prdata}, re)
        end
        if ((join_ack_r || join_refuse_r) && ackq.size() > 0) begin
            ae = ackq.pop_front();
            `CHK({join_ack_r, join_refuse_r}, ae)
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        wrap_up;
    end
    initial begin
        void'($urandom(71));
        m0 = 8'($urandom);
        m1 = 8'($urandom);
        start(32'h1);
        rdq.push_back({1'b1, 32'h0});
        xfer(1'b0, 12'h800, 32'h0);
        rd(`ADDR_TABLE_BASE, {23'h0, 1'b1, m0});
        join_exp(6'd0, m0, 1'b0, 1'b1);
        repeat (130) @(posedge clk);
        rd(`ADDR_STATE, 32'h2);
        red_count;
        `CHK(cnt, 8)
        `CHK(io_run_r, 1'b1)
        `CHK(ns_green, 1'b0)
        wr(`ADDR_CMD, 32'h1);
        rd(`ADDR_MISSING, 32'h2);
        join_exp(6'd1, m1, 1'b0, 1'b1);
        red_count;
        `CHK(cnt, 0)
        `CHK(ns_green, 1'b1)
        rd(`ADDR_STATE, 32'h0);
        wr(`ADDR_CMD, 32'h4);
        rd(`ADDR_EXAMPLE_BASE, {23'h0, 1'b1, m0});
        net_i.evt(4'b1000, 6'd0);
        rd(`ADDR_COMMERR, 32'h1);
        rd(`ADDR_PART, 32'h3);
        net_i.evt(4'b0100, 6'd0);
        rd(`ADDR_COMMERR, 32'h0);
        net_i.evt(4'b0010, 6'd3);
        net_i.evt(4'b0001, 6'd4);
        join_exp(6'd5, 8'($urandom), 1'b0, 1'b0);
        red_count;
        `CHK(cnt, 8)
        wr(`ADDR_CMD, 32'h1);
        rd(`ADDR_DUPERR, 32'h18);
        rd(`ADDR_UNREG, 32'h20);
        join_exp(6'd7, m1, 1'b1, 1'b0);
        rd(`ADDR_EVONLY, 32'h0);
        wr(`ADDR_CMD, 32'h1);
        rd(`ADDR_EVONLY, 32'h80);
        start(32'h1);
        rd(`ADDR_PART, 32'h0);
        join_exp(6'd0, m0, 1'b0, 1'b1);
        join_exp(6'd1, m1, 1'b0, 1'b1);
        rd(`ADDR_STATE, 32'h40);
        start(32'h3);
        join_exp(6'd0, m0, 1'b0, 1'b1);
        repeat (130) @(posedge clk);
        `CHK(io_run_r, 1'b0)
        rd(`ADDR_STATE, 32'h0);
        join_exp(6'd1, m1, 1'b0, 1'b1);
        repeat (3) @(posedge clk);
        `CHK(io_run_r, 1'b1)
        start(32'hD);
        repeat (130) @(posedge clk);
        `CHK(io_run_r, 1'b0)
        rd(`ADDR_STATE, 32'h0);
        wr(`ADDR_CMD, 32'h2);
        repeat (200) @(posedge clk);
        rd(`ADDR_STATE, 32'h0);
        repeat (130) @(posedge clk);
        rd(`ADDR_STATE, 32'h2);
        `CHK(io_run_r, 1'b1)
        wrap_up;
    end
endmodule
`default_nettype wire
